// file: tks_touch_sense.sv
// Touch key sense configuration, averaging filters and auto detection.
//
// Functional notes
// - With dithering on, a 255-long pseudo-random sequence steps every sense cycle and varies the current.
// - Narrow dither takes 3 random bits and uses them only when odd, else the programmed code.
// - Wide dither takes 4 random bits and uses them only when odd, else the programmed code.
// - The 4-bit current code goes to the front end as the current step selection.
// - The scale bit tells the front end to use sixteen times the current.
// - Each capture updates the slow average: load, or divide by 16, 32, 64 or 128; other codes reserved.
// - Each capture updates the fast average: load, or divide by 2, 4, 8 or 16; other codes reserved.
// - A 22-bit detect threshold sits in three byte registers, low byte first, all read and write.
// - A 2-bit delay field picks a hold-off of 64, 256, 512 or 1024 captures with no detection.
// - Reset clears the analog, filter, threshold and timer registers to zero.
// - The filter register holds the slow code in bits 7..4 and the fast code in bits 3..0.
// - In automatic mode a started capture repeats until a touch is detected.
// - Writing the start command to zero aborts a capture in progress.
// - The busy flag is high while a capture is in progress and low otherwise.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

module tks_touch_sense
    import tks_pkg::*;
#(
    parameter int CAP_W = CAPTURE_W
) (
    // Clock, reset and clock enable.
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                ce,
    // Register port.
    input  wire logic [15:0]         regAddr,
    input  wire logic [7:0]          regWdata,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic      [7:0]          regRdata,
    // Interrupt.
    output logic                     irq,
    // Analog front end settings.
    output logic      [3:0]          currentCode,
    output logic                     currentScaleX16,
    output logic                     comparatorFast,
    output logic                     senseRun,
    output logic      [TIMER_W-1:0]  senseTimerValue,
    // Analog front end results.
    input  wire logic                senseCycleToggle,
    input  wire logic                captureToggle,
    input  wire logic [CAP_W-1:0]    captureValue
);

    // Refuse capture widths that cannot hold the threshold.
    if (CAP_W < THRESHOLD_W || CAP_W > 30) begin : g_cap_w_check
        $error("tks_touch_sense: CAP_W out of range");
    end

    // Register state.
    logic [7:0]          analogCfgQ, analogCfgD;
    logic [7:0]          filterCfgQ, filterCfgD;
    logic [7:0]          limit0Q, limit0D;
    logic [7:0]          limit1Q, limit1D;
    logic [7:0]          limit2Q, limit2D;
    logic [TIMER_W-1:0]  timerQ, timerD;
    logic                enableQ, enableD;
    logic                autoQ, autoD;
    logic                startQ, startD;
    logic [IRQ_BITS-1:0] statusQ, statusD;
    logic [IRQ_BITS-1:0] maskQ, maskD;
    logic [7:0]          rdataQ, rdataD;
    logic                irqQ, irqD;

    // Sequencer and filter state.
    tks_state_t          stateQ, stateD;
    logic [CAP_W-1:0]    slowAvgQ, slowAvgD;
    logic [CAP_W-1:0]    fastAvgQ, fastAvgD;
    logic [10:0]         settleCntQ, settleCntD;
    logic [7:0]          lfsrQ, lfsrD;
    logic [3:0]          codeQ, codeD;

    // Synchronisers for front end inputs.
    logic [2:0]          capSyncQ;
    logic [2:0]          cycSyncQ;
    logic [CAP_W-1:0]    valSync1Q, valSync2Q;

    // Decoded events and fields.
    logic                capEvent;
    logic                cycEvent;
    logic [THRESHOLD_W-1:0] threshold;
    logic [10:0]         holdoff;
    logic [CAP_W:0]      diff;
    logic [CAP_W-1:0]    diffMag;
    logic                touchHit;

    // Moving average step: old + (new - old) / 2^sh, widened for the sum.
    function automatic logic [CAP_W-1:0] avgStep(
        input logic [CAP_W-1:0] oldV,
        input logic [CAP_W-1:0] newV,
        input logic [3:0]       sh
    );
        logic [CAP_W+8:0] acc;
        acc = ({9'h000, oldV} << sh) - {9'h000, oldV} + {9'h000, newV};
        acc = acc >> sh;
        return acc[CAP_W-1:0];
    endfunction

    // Write strobe for one register address.
    function automatic logic hitWr(input logic [15:0] a);
        return regWr && (regAddr == a);
    endfunction

    // Front end events: two flops for the crossing, the third for edges.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            capSyncQ  <= 3'h0;
            cycSyncQ  <= 3'h0;
            valSync1Q <= '0;
            valSync2Q <= '0;
        end else if (ce) begin
            capSyncQ  <= {capSyncQ[1:0], captureToggle};
            cycSyncQ  <= {cycSyncQ[1:0], senseCycleToggle};
            valSync1Q <= captureValue;
            valSync2Q <= valSync1Q;
        end
    end

    // Events seen past the second flop only.
    assign capEvent = capSyncQ[2] ^ capSyncQ[1];
    assign cycEvent = cycSyncQ[2] ^ cycSyncQ[1];

    // Field decode of the threshold byte registers.
    // Threshold assembly, low first.
    assign threshold = {limit2Q[5:0], limit1Q, limit0Q};

    always_comb begin
        unique case (limit2Q[LIM_DELAY_LSB +: 2])
            2'h0:    holdoff = HOLDOFF_0;
            2'h1:    holdoff = HOLDOFF_1;
            2'h2:    holdoff = HOLDOFF_2;
            default: holdoff = HOLDOFF_3;
        endcase
    end

    // Fast minus slow compared with threshold.
    always_comb begin
        diff = {1'b0, fastAvgD} - {1'b0, slowAvgD};
        if (limit2Q[LIM_ABS_SEL] && diff[CAP_W]) begin
            diffMag = slowAvgD - fastAvgD;
        end else if (diff[CAP_W]) begin
            diffMag = '0;
        end else begin
            diffMag = diff[CAP_W-1:0];
        end
        touchHit = diffMag > {{(CAP_W-THRESHOLD_W){1'b0}}, threshold};
    end

    // Register writes, capture sequencing, filters and interrupt status.
    always_comb begin
        analogCfgD = analogCfgQ;
        filterCfgD = filterCfgQ;
        limit0D    = limit0Q;
        limit1D    = limit1Q;
        limit2D    = limit2Q;
        timerD     = timerQ;
        enableD    = enableQ;
        autoD      = autoQ;
        startD     = startQ;
        maskD      = maskQ;
        stateD     = stateQ;
        slowAvgD   = slowAvgQ;
        fastAvgD   = fastAvgQ;
        settleCntD = settleCntQ;
        statusD    = statusQ;

        // Plain configuration registers.
        if (hitWr(ADDR_ANALOG_CFG)) begin
            analogCfgD = regWdata;
        end
        if (hitWr(ADDR_FILTER_CFG)) begin
            filterCfgD = regWdata;
        end
        if (hitWr(ADDR_LIMIT_B0)) begin
            limit0D = regWdata;
        end
        if (hitWr(ADDR_LIMIT_B1)) begin
            limit1D = regWdata;
        end
        if (hitWr(ADDR_LIMIT_B2)) begin
            limit2D = regWdata;
        end
        if (hitWr(ADDR_TIMER_B0)) begin
            timerD[7:0] = regWdata;
        end
        if (hitWr(ADDR_TIMER_B1)) begin
            timerD[15:8] = regWdata;
        end
        if (hitWr(ADDR_TIMER_B2)) begin
            timerD[23:16] = regWdata;
        end
        if (hitWr(ADDR_IRQ_MASK)) begin
            maskD = regWdata[IRQ_BITS-1:0];
        end
        // Write one to clear; hardware sets below win.
        if (hitWr(ADDR_IRQ_STATUS)) begin
            statusD = statusQ & ~regWdata[IRQ_BITS-1:0];
        end
        // Control write; a start from idle restarts the hold-off.
        if (hitWr(ADDR_CONTROL)) begin
            enableD = regWdata[CTL_ENABLE];
            autoD   = regWdata[CTL_AUTO];
            startD  = regWdata[CTL_START] && regWdata[CTL_ENABLE];
        end

        unique case (stateQ)
            ST_IDLE: begin
                if (startD) begin
                    stateD     = ST_RUN;
                    settleCntD = 11'h000;
                end
            end
            ST_RUN: begin
                if (!startD) begin
                    stateD = ST_IDLE;
                end else if (capEvent) begin
                    if (filterCfgQ[FILT_SLOW_LSB +: 4] == 4'h0) begin
                        slowAvgD = valSync2Q;
                    end else if (filterCfgQ[FILT_SLOW_LSB +: 4]
                                 <= FILT_MAX_CODE) begin
                        slowAvgD = avgStep(slowAvgQ, valSync2Q,
                            filterCfgQ[FILT_SLOW_LSB +: 4] + SLOW_SHIFT_OFS);
                    end
                    if (filterCfgQ[FILT_FAST_LSB +: 4] == 4'h0) begin
                        fastAvgD = valSync2Q;
                    end else if (filterCfgQ[FILT_FAST_LSB +: 4]
                                 <= FILT_MAX_CODE) begin
                        fastAvgD = avgStep(fastAvgQ, valSync2Q,
                            filterCfgQ[FILT_FAST_LSB +: 4]);
                    end
                    statusD[IRQ_CAPTURE] = 1'b1;
                    if (settleCntQ < holdoff) begin
                        settleCntD = settleCntQ + 11'h001;
                    end
                    if (!autoQ) begin
                        startD = 1'b0;
                        stateD = ST_IDLE;
                    end else if (settleCntQ >= holdoff && touchHit) begin
                        statusD[IRQ_TOUCH] = 1'b1;
                        startD = 1'b0;
                        stateD = ST_IDLE;
                    end
                end
            end
        endcase

        // Interrupt level follows next status and mask.
        irqD = |(statusD & maskD);
    end

    // Dither sequence and current code selection.
    always_comb begin
        lfsrD = lfsrQ;
        codeD = analogCfgD[CFG_CODE_LSB +: 4];
        // Maximal length 8-bit sequence, 255 states.
        if (cycEvent && analogCfgQ[CFG_DITHER_EN]) begin
            lfsrD = {lfsrQ[6:0],
                     lfsrQ[7] ^ lfsrQ[5] ^ lfsrQ[4] ^ lfsrQ[3]};
        end
        if (analogCfgD[CFG_DITHER_EN]) begin
            if (!analogCfgD[CFG_DITHER_WIDE]) begin
                if (lfsrD[0]) begin
                    codeD = {1'b0, lfsrD[2:0]};
                end
            end else begin
                if (lfsrD[0]) begin
                    codeD = lfsrD[3:0];
                end
            end
        end
    end

    // Read data for the cycle after the read strobe; unmapped reads zero.
    always_comb begin
        rdataD = 8'h00;
        if (regRd) begin
            unique case (regAddr)
                ADDR_ANALOG_CFG: rdataD = analogCfgQ;
                ADDR_FILTER_CFG: rdataD = filterCfgQ;
                ADDR_LIMIT_B0:   rdataD = limit0Q;
                ADDR_LIMIT_B1:   rdataD = limit1Q;
                ADDR_LIMIT_B2:   rdataD = limit2Q;
                ADDR_TIMER_B0:   rdataD = timerQ[7:0];
                ADDR_TIMER_B1:   rdataD = timerQ[15:8];
                ADDR_TIMER_B2:   rdataD = timerQ[23:16];
                ADDR_CONTROL:    rdataD = {4'h0, stateQ == ST_RUN, startQ,
                                           autoQ, enableQ};
                ADDR_IRQ_STATUS: rdataD = {6'h00, statusQ};
                ADDR_IRQ_MASK:   rdataD = {6'h00, maskQ};
                default:         rdataD = 8'h00;
            endcase
        end
    end

    // State registers; clock enable low freezes everything.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            analogCfgQ <= REG_RESET;
            filterCfgQ <= REG_RESET;
            limit0Q    <= REG_RESET;
            limit1Q    <= REG_RESET;
            limit2Q    <= REG_RESET;
            timerQ     <= '0;
            enableQ    <= 1'b0;
            autoQ      <= 1'b0;
            startQ     <= 1'b0;
            statusQ    <= '0;
            maskQ      <= '0;
            rdataQ     <= 8'h00;
            irqQ       <= 1'b0;
            stateQ     <= ST_IDLE;
            slowAvgQ   <= '0;
            fastAvgQ   <= '0;
            settleCntQ <= 11'h000;
            lfsrQ      <= LFSR_SEED;
            codeQ      <= 4'h0;
        end else if (ce) begin
            analogCfgQ <= analogCfgD;
            filterCfgQ <= filterCfgD;
            limit0Q    <= limit0D;
            limit1Q    <= limit1D;
            limit2Q    <= limit2D;
            timerQ     <= timerD;
            enableQ    <= enableD;
            autoQ      <= autoD;
            startQ     <= startD;
            statusQ    <= statusD;
            maskQ      <= maskD;
            rdataQ     <= rdataD;
            irqQ       <= irqD;
            stateQ     <= stateD;
            slowAvgQ   <= slowAvgD;
            fastAvgQ   <= fastAvgD;
            settleCntQ <= settleCntD;
            lfsrQ      <= lfsrD;
            codeQ      <= codeD;
        end
    end

    // Outputs straight from flops.
    assign regRdata        = rdataQ;
    assign irq             = irqQ;
    // Current step code to the front end.
    assign currentCode     = codeQ;
    assign currentScaleX16 = analogCfgQ[CFG_SCALE_X16];
    assign comparatorFast  = analogCfgQ[CFG_COMP_FAST];
    assign senseRun        = stateQ[1]; // One-hot run bit.
    assign senseTimerValue = timerQ;

endmodule // tks_touch_sense

// file: tks_pkg.sv
// Package with register map, field layout and constants of the touch sense block.
package tks_pkg;

    // Register byte addresses.
    localparam logic [15:0] ADDR_ANALOG_CFG = 16'hA131;
    localparam logic [15:0] ADDR_FILTER_CFG = 16'hA132;
    localparam logic [15:0] ADDR_LIMIT_B0   = 16'hA133;
    localparam logic [15:0] ADDR_LIMIT_B1   = 16'hA134;
    localparam logic [15:0] ADDR_LIMIT_B2   = 16'hA135;
    localparam logic [15:0] ADDR_TIMER_B0   = 16'hA140;
    localparam logic [15:0] ADDR_TIMER_B1   = 16'hA141;
    localparam logic [15:0] ADDR_TIMER_B2   = 16'hA142;
    localparam logic [15:0] ADDR_CONTROL    = 16'hA150;
    localparam logic [15:0] ADDR_IRQ_STATUS = 16'hA151;
    localparam logic [15:0] ADDR_IRQ_MASK   = 16'hA152;

    // Common reset value of all byte registers.
    localparam logic [7:0] REG_RESET = 8'h00;

    // Analog configuration field positions.
    localparam int CFG_COMP_FAST   = 7;
    localparam int CFG_DITHER_EN   = 6;
    localparam int CFG_DITHER_WIDE = 5;
    localparam int CFG_SCALE_X16   = 4;
    localparam int CFG_CODE_LSB    = 0;

    // Filter configuration field positions.
    localparam int FILT_SLOW_LSB = 4;
    localparam int FILT_FAST_LSB = 0;

    // Threshold byte 2 field positions.
    localparam int LIM_ABS_SEL   = 7;
    localparam int LIM_DELAY_LSB = 5;

    // Control register field positions.
    localparam int CTL_ENABLE = 0;
    localparam int CTL_AUTO   = 1;
    localparam int CTL_START  = 2;
    localparam int CTL_BUSY   = 3;

    // Interrupt status and mask bit positions.
    localparam int IRQ_TOUCH   = 0;
    localparam int IRQ_CAPTURE = 1;
    localparam int IRQ_BITS    = 2;

    // Widths of the data paths.
    localparam int CAPTURE_W   = 24;
    localparam int THRESHOLD_W = 22;
    localparam int TIMER_W     = 24;

    // Hold-off lengths in captures for delay codes 0 to 3.
    localparam logic [10:0] HOLDOFF_0 = 11'h040;
    localparam logic [10:0] HOLDOFF_1 = 11'h100;
    localparam logic [10:0] HOLDOFF_2 = 11'h200;
    localparam logic [10:0] HOLDOFF_3 = 11'h400;

    // Highest valid filter code; above it the average is held.
    localparam logic [3:0] FILT_MAX_CODE = 4'h4;
    // Slow filter shift is its code plus this offset.
    localparam logic [3:0] SLOW_SHIFT_OFS = 4'h3;

    // Dither sequence generator seed; any nonzero value serves.
    localparam logic [7:0] LFSR_SEED = 8'h01;

    // Capture sequencer states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } tks_state_t;

endpackage

// file: tks_touch_sense_asserts.sv
// Concurrent checks on the ports of the touch sense block.
`timescale 1ns/1ps
module tks_touch_sense_checker
    import tks_pkg::*;
(
    // Clock, reset and clock enable.
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic               ce,
    // Register port.
    input wire logic [15:0]        regAddr,
    input wire logic [7:0]         regWdata,
    input wire logic               regWr,
    input wire logic               regRd,
    input wire logic [7:0]         regRdata,
    // Outputs.
    input wire logic               irq,
    input wire logic [3:0]         currentCode,
    input wire logic               currentScaleX16,
    input wire logic               comparatorFast,
    input wire logic               senseRun,
    input wire logic [TIMER_W-1:0] senseTimerValue
);
    logic [7:0]  cfg_q, cfg_d;
    logic [23:0] tmr_q, tmr_d;
    logic [1:0]  age_q, age_d;
    logic        wrOk;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Shadows of the analog and timer bytes, and cycles since they changed.
    assign wrOk = regWr && ce;
    always_comb begin
        cfg_d = cfg_q;
        tmr_d = tmr_q;
        if (wrOk && regAddr == ADDR_ANALOG_CFG) cfg_d = regWdata;
        if (wrOk && regAddr == ADDR_TIMER_B0) tmr_d[7:0] = regWdata;
        if (wrOk && regAddr == ADDR_TIMER_B1) tmr_d[15:8] = regWdata;
        if (wrOk && regAddr == ADDR_TIMER_B2) tmr_d[23:16] = regWdata;
        age_d = (cfg_d != cfg_q || tmr_d != tmr_q) ? 2'h0 :
                (age_q == 2'h3) ? 2'h3 : age_q + 2'h1;
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= 8'h00;
            tmr_q <= 24'h000000;
            age_q <= 2'h3;
        end else begin
            cfg_q <= cfg_d;
            tmr_q <= tmr_d;
            age_q <= age_d;
        end
    end

    a_read_idle_zero: assert property (
        !$past(regRd && ce) |-> regRdata == 8'h00)
        else $error("read data not zero outside a read");
    a_read_cfg_value: assert property (
        regRd && ce && regAddr == ADDR_ANALOG_CFG |=> regRdata == $past(cfg_q))
        else $error("analog byte read back wrong");
    a_code_follows_cfg: assert property (
        age_q == 2'h3 && !cfg_q[CFG_DITHER_EN] |-> currentCode == cfg_q[3:0])
        else $error("current code differs from programmed code");
    a_scale_follows_cfg: assert property (
        age_q == 2'h3 |-> currentScaleX16 == cfg_q[CFG_SCALE_X16] &&
        comparatorFast == cfg_q[CFG_COMP_FAST])
        else $error("scale or comparator bit wrong");
    a_dither_narrow_code: assert property (
        age_q == 2'h3 && cfg_q[CFG_DITHER_EN] && !cfg_q[CFG_DITHER_WIDE] |->
        currentCode == cfg_q[3:0] ||
        (currentCode[0] && !currentCode[3]))
        else $error("narrow dither code out of set");
    a_dither_wide_code: assert property (
        age_q == 2'h3 && cfg_q[CFG_DITHER_EN] && cfg_q[CFG_DITHER_WIDE] |->
        currentCode == cfg_q[3:0] || currentCode[0])
        else $error("wide dither code out of set");
    a_timer_bytes: assert property (
        age_q == 2'h3 |-> senseTimerValue == tmr_q)
        else $error("timer value differs from its bytes");
    a_start_sets_busy: assert property (
        wrOk && regAddr == ADDR_CONTROL && regWdata[CTL_ENABLE] &&
        regWdata[CTL_START] |=> senseRun)
        else $error("busy not set by start");
    a_abort_clears_busy: assert property (
        wrOk && regAddr == ADDR_CONTROL && !regWdata[CTL_START] |=> !senseRun)
        else $error("busy not cleared by abort");
    a_reset_clears_out: assert property (disable iff (1'b0)
        !nrst |-> senseTimerValue == 24'h000000 && currentCode == 4'h0 && !irq)
        else $error("outputs not cleared in reset");

    // Main scenarios reached.
    c_start: cover property (wrOk && regAddr == ADDR_CONTROL && regWdata[2]);
    c_irq: cover property ($rose(irq));
    c_busy_end: cover property ($fell(senseRun));
    c_dither: cover property (cfg_q[6] && currentCode != cfg_q[3:0]);
endmodule // tks_touch_sense_checker

bind tks_touch_sense tks_touch_sense_checker u_tks_touch_sense_checker (
    .clk, .nrst, .ce, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .irq,
    .currentCode, .currentScaleX16, .comparatorFast, .senseRun,
    .senseTimerValue
);

// file: tks_pad_model.sv
// Behavioural model of the touch pad and its analog sense front end.
`timescale 1ns/1ps
module tks_pad_model (
    // Clock and sequencer state.
    input  wire logic        clk,
    input  wire logic        senseRun,
    // Capture spacing in clocks and the pad reading.
    input  wire logic [7:0]  gap,
    input  wire logic [23:0] level,
    // Front end results.
    output logic             senseCycleToggle,
    output logic             captureToggle,
    output logic [23:0]      captureValue
);
    logic [7:0] cnt   = 8'h00;
    logic       armed = 1'b0;

    initial begin
        senseCycleToggle = 1'b0;
        captureToggle    = 1'b0;
        captureValue     = 24'h000000;
    end

    // A capture presents its value two clocks before the toggle and holds
    // it for the rest of the gap; when idle the value keeps changing.
    always @(posedge clk) begin
        cnt <= (cnt >= gap - 8'h01) ? 8'h00 : cnt + 8'h01;
        if (cnt == 8'h00) begin
            armed        <= senseRun;
            captureValue <= senseRun ? level : ~captureValue;
        end
        if (armed && senseRun && cnt == 8'h02)
            captureToggle <= ~captureToggle;
        if (senseRun && cnt[0])
            senseCycleToggle <= ~senseCycleToggle;
    end
endmodule // tks_pad_model

// file: testbench.sv
// Self-checking testbench of the touch sense block.
`timescale 1ns/1ps
module testbench;
    import tks_pkg::*;

    logic        clk, nrst, regWr, regRd, irq, senseRun, scl, cfast;
    logic        cycTgl, capTgl;
    logic [15:0] regAddr;
    logic [7:0]  regWdata, regRdata, gap, val, cfg;
    logic [3:0]  currentCode;
    logic [23:0] level, capVal, tmrOut;
    longint      mf, ms, thr;
    int          errors, num_checks, fc, sc, hold, mn, expDet, cnt, seen;
    bit          autoOn;
    logic [15:0] regs[8] = '{ADDR_ANALOG_CFG, ADDR_FILTER_CFG, ADDR_LIMIT_B0,
        ADDR_LIMIT_B1, ADDR_LIMIT_B2, ADDR_TIMER_B0, ADDR_TIMER_B1,
        ADDR_TIMER_B2};
    logic [7:0]  wv[8];
    int          holds[4] = '{HOLDOFF_0, HOLDOFF_1, HOLDOFF_2, HOLDOFF_3};

    tks_touch_sense u_tks_touch_sense (
        .clk(clk), .nrst(nrst), .ce(1'b1), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .irq(irq), .currentCode(currentCode),
        .currentScaleX16(scl), .comparatorFast(cfast), .senseRun(senseRun),
        .senseTimerValue(tmrOut), .senseCycleToggle(cycTgl),
        .captureToggle(capTgl), .captureValue(capVal)
    );
    tks_pad_model u_tks_pad_model (
        .clk(clk), .senseRun(senseRun), .gap(gap), .level(level),
        .senseCycleToggle(cycTgl), .captureToggle(capTgl),
        .captureValue(capVal)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        check(regRdata, exp);
    endtask

    // Reference averages stepped by one capture; detection noted once.
    task automatic model_step(input longint v);
        mn++;
        if (fc == 0) mf = v;
        else if (fc <= 4) mf = ((mf << fc) - mf + v) >> fc;
        if (sc == 0) ms = v;
        else if (sc <= 4) ms = ((ms << (sc + 3)) - ms + v) >> (sc + 3);
        // no detection within the hold-off captures, then threshold.
        if (autoOn && mn > hold && mf - ms > thr && expDet == 0) expDet = mn;
    endtask

    // Follows captures until the sequencer stops or the limit is reached.
    task automatic run(input int lim);
        logic last;
        cnt = 0;
        @(negedge clk);
        last = capTgl;
        for (int c = 0; c < 20000 && senseRun && cnt < lim; c++) begin
            @(negedge clk);
            if (capTgl !== last) begin
                cnt++;
                model_step(level);
            end
            if (currentCode !== cfg[3:0]) seen++;
            last = capTgl;
        end
        repeat (6) @(negedge clk);
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog against a hung sequencer.
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        complete_run();
    end

    initial begin
        nrst = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 16'h0000;
        regWdata = 8'h00; level = 24'h000000; gap = 8'h08; cfg = 8'h00;
        val = 8'($urandom(20897));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        // Reset values, then random bytes read back as written.
        foreach (regs[i]) rd_chk(regs[i], REG_RESET);
        wr(16'hA13F, 8'hFF);
        rd_chk(16'hA13F, 8'h00);
        foreach (regs[i]) begin
            wv[i] = 8'($urandom);
            wr(regs[i], wv[i]);
        end
        foreach (regs[i]) rd_chk(regs[i], wv[i]);
        check(tmrOut, {wv[7], wv[6], wv[5]});
        check({cfast, scl}, {wv[0][7], wv[0][4]});
        // One capture without automatic mode; masked, then raised, cleared.
        cfg = 8'h03;
        wr(ADDR_ANALOG_CFG, cfg);
        wr(ADDR_FILTER_CFG, 8'h00);
        level <= 24'($urandom);
        wr(ADDR_CONTROL, 8'h05);
        run(1000);
        check(cnt, 1);
        check(senseRun, 1'b0);
        check(irq, 1'b0);
        check(currentCode, cfg[3:0]);
        wr(ADDR_IRQ_MASK, 8'h03);
        repeat (2) @(negedge clk);
        check(irq, 1'b1);
        rd_chk(ADDR_IRQ_STATUS, 8'h02);
        wr(ADDR_IRQ_STATUS, 8'h02);
        repeat (2) @(negedge clk);
        check(irq, 1'b0);
        // Automatic runs over every delay code, with dither on.
        gap    = 8'h0C;
        autoOn = 1'b1;
        for (int d = 0; d < 4; d++) begin
            fc   = $urandom_range(4);
            sc   = $urandom_range(5, 1);
            hold = holds[d];
            thr  = $urandom_range(150) + ((d & 1) << 21);
            val  = 8'($urandom);
            cfg  = {val[7], 1'b1, 1'(d), val[4], 4'hA};
            wr(ADDR_ANALOG_CFG, cfg);
            wr(ADDR_FILTER_CFG, 8'((sc << 4) | fc));
            wr(ADDR_LIMIT_B0, 8'(thr));
            wr(ADDR_LIMIT_B1, 8'h00);
            wr(ADDR_LIMIT_B2, 8'(d << 5));
            level <= 24'($urandom);
            mn     = 0;
            expDet = 0;
            wr(ADDR_CONTROL, 8'h07);
            run(hold + 100);
            if (expDet == 0) begin
                check(senseRun, 1'b1);
                wr(ADDR_CONTROL, 8'h03);
                @(negedge clk);
                check(senseRun, 1'b0);
            end
            check(cnt, (expDet != 0) ? expDet : hold + 100);
            check(senseRun, 1'b0);
            rd_chk(ADDR_IRQ_STATUS, (expDet != 0) ? 8'h03 : 8'h02);
            wr(ADDR_IRQ_STATUS, 8'h03);
            repeat (2) @(negedge clk);
            check(irq, 1'b0);
        end
        check(seen > 0, 1'b1);
        complete_run();
    end
endmodule // testbench
